// ===== pkg/host_port_pkg.sv
// constants shared by the strobed host input port and its leaf modules
package host_port_pkg;

  localparam int DATA_W = 8;
  localparam int RAM_DEPTH = 256;
  localparam int RAM_ADDR_W = 8;
  localparam int HEAD_PINS = 9;
  localparam int SYNC_STAGES = 2;

  // i/o space addresses on the multiplexed bus
  localparam logic [7:0] IO_ADDR_CMD = 8'h00;
  localparam logic [7:0] IO_ADDR_STATUS = 8'h00;
  localparam logic [7:0] IO_ADDR_PORT_A = 8'h01;
  localparam logic [7:0] IO_ADDR_PORT_B = 8'h02;
  localparam logic [7:0] IO_ADDR_PORT_C = 8'h03;
  localparam logic [7:0] IO_ADDR_LIMIT = 8'h04;

  // command register fields
  localparam int CMD_PA_OUT_BIT = 0;
  localparam int CMD_STROBED_BIT = 1;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;

  // port c write field: head pin nine
  localparam int PC_HEAD9_BIT = 4;

  // current limit register fields
  localparam int LIM_CARRIAGE_BIT = 0;
  localparam int LIM_FEED_BIT = 1;
  localparam logic [1:0] LIM_RESET_VAL = 2'h3;

  // status register fields
  localparam int ST_FULL_BIT = 0;
  localparam int ST_STROBED_BIT = 1;
  localparam int ST_FAIL_BIT = 2;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_READ = 3'b010,
    BUS_WRITE = 3'b100
  } bus_state_t;

endpackage : host_port_pkg

// ===== rtl/byte_store_ram.sv
// single-port byte store with registered read data
`timescale 1ns/100ps
module byte_store_ram #(
  parameter int DEPTH = host_port_pkg::RAM_DEPTH,
  parameter int ADDR_W = host_port_pkg::RAM_ADDR_W,
  parameter int DATA_W = host_port_pkg::DATA_W
) (
  // clock
  input wire logic clk_in,
  // access
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic wr_en_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  output logic [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rd_data_r;

  // contents are not cleared by reset, as in a real static ram
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wr_data_in;
    end
    rd_data_r <= mem[addr_in];
  end

  assign rd_data_out = rd_data_r;

endmodule : byte_store_ram

// ===== rtl/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = rst_in ? RESET_VAL : async_in;
    sync_nxt = rst_in ? RESET_VAL : meta_r;
  end

  always_ff @(posedge clk_in) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_out = sync_r;

endmodule : pin_sync

// ===== rtl/strobed_host_input_port.sv
// strobed host input port with byte store and print head drive outputs
//
// Behaviour
// RL1 - port runs strobed input mode only after the controller commands it
// RL2 - host strobe arrives on port c bit 2 as an input
// RL3 - eight host data bits enter on port a lines 0 to 7
// RL4 - host byte is captured on the strobe's trailing edge
// RL5 - ready on port c bit 1 rises right after a byte is captured
// RL6 - host sets data then gives exactly one strobe pulse per byte
// RL7 - nine head solenoid outputs from port b lines and port c bit 4
// RL8 - internal 256-byte store holds received print data
// RL9 - controller reaches commands and data over 8-bit muxed address/data bus
// RL10 - port a lines also serve the expansion connector, both directions
// RL11 - supply failure forces the control logic back to its initial state
// RL12 - motor current limit outputs reduce heating while motors idle
// RL13 - ready stays high until the controller has read the captured byte; the code also drops it when strobed mode is left
`timescale 1ns/100ps
module strobed_host_input_port (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // host side
  input wire logic port_c_bit2_strobe_n_in,
  input wire logic [7:0] port_a_lines_in,
  output logic [7:0] port_a_lines_out,
  output logic port_a_lines_oe_out,
  output logic port_c_bit1_out,
  // print head drive
  output logic [7:0] port_b_lines_out,
  output logic port_c_bit4_out,
  // motor current limiting
  output logic carriage_current_limit_out,
  output logic feed_current_limit_out,
  // controller multiplexed bus
  input wire logic [7:0] muxed_addr_data_bus_in,
  output logic [7:0] muxed_addr_data_bus_out,
  output logic muxed_addr_data_bus_oe_out,
  input wire logic addr_latch_en_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic chip_sel_n_in,
  input wire logic io_sel_in,
  // supply monitor
  input wire logic supply_fail_in,
  output logic ctrl_reset_out
);
  localparam int DW = host_port_pkg::DATA_W;
  // synchronised pins
  logic [DW:0] host_s;
  logic [DW+5:0] bus_s;
  logic strobe_n_s;
  logic [DW-1:0] pa_s;
  logic [DW-1:0] ad_s;
  logic ale_s;
  logic rd_n_s;
  logic wr_n_s;
  logic cs_n_s;
  logic io_s;
  logic fail_s;

  pin_sync #(
    .WIDTH(DW + 1),
    .RESET_VAL({1'b1, host_port_pkg::BYTE_ZERO})
  ) u_host_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({port_c_bit2_strobe_n_in, port_a_lines_in}), // see RL2 RL3
    .sync_out(host_s)
  );

  pin_sync #(
    .WIDTH(DW + 6),
    .RESET_VAL({6'h0e, host_port_pkg::BYTE_ZERO})
  ) u_bus_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({supply_fail_in, addr_latch_en_in, rd_n_in, wr_n_in,
               chip_sel_n_in, io_sel_in, muxed_addr_data_bus_in}),
    .sync_out(bus_s)
  );

  assign strobe_n_s = host_s[DW];
  assign pa_s = host_s[DW-1:0];
  assign ad_s = bus_s[DW-1:0];
  assign io_s = bus_s[DW];
  assign cs_n_s = bus_s[DW+1];
  assign wr_n_s = bus_s[DW+2];
  assign rd_n_s = bus_s[DW+3];
  assign ale_s = bus_s[DW+4];
  assign fail_s = bus_s[DW+5];

  // generated reset from the supply monitor
  logic gen_rst_r;
  logic gen_rst_nxt;
  logic ctl_rst;
  always_comb begin
    gen_rst_nxt = rst_in | fail_s; // see RL11
  end
  always_ff @(posedge clk_in) begin
    gen_rst_r <= gen_rst_nxt;
  end
  // held one cycle longer than the failure so the logic restarts cleanly
  assign ctl_rst = rst_in | fail_s | gen_rst_r; // see RL11

  // bus phase tracking
  host_port_pkg::bus_state_t state_r;
  host_port_pkg::bus_state_t state_nxt;
  logic ale_prev_r;
  logic ale_prev_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic io_r;
  logic io_nxt;
  logic rd_done;
  logic wr_done;
  always_comb begin
    state_nxt = state_r;
    rd_done = 1'b0;
    wr_done = 1'b0;
    ale_prev_nxt = ale_s;
    addr_nxt = addr_r;
    io_nxt = io_r;
    // address and space select are taken as the latch enable falls
    if (ale_prev_r && !ale_s) begin // see RL9
      addr_nxt = ad_s;
      io_nxt = io_s;
    end
    case (state_r)
      host_port_pkg::BUS_IDLE: begin
        if (!cs_n_s && !rd_n_s) begin
          state_nxt = host_port_pkg::BUS_READ;
        end else if (!cs_n_s && !wr_n_s) begin
          state_nxt = host_port_pkg::BUS_WRITE;
        end
      end
      host_port_pkg::BUS_READ: begin
        if (rd_n_s) begin
          rd_done = 1'b1;
          state_nxt = host_port_pkg::BUS_IDLE;
        end
      end
      host_port_pkg::BUS_WRITE: begin
        // data is taken at the trailing edge of the write strobe
        if (wr_n_s) begin
          wr_done = 1'b1;
          state_nxt = host_port_pkg::BUS_IDLE;
        end
      end
      default: begin
        state_nxt = host_port_pkg::BUS_IDLE;
      end
    endcase
    if (ctl_rst) begin
      state_nxt = host_port_pkg::BUS_IDLE;
      ale_prev_nxt = 1'b0;
      addr_nxt = host_port_pkg::BYTE_ZERO;
      io_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_in) begin
    state_r <= state_nxt;
    ale_prev_r <= ale_prev_nxt;
    addr_r <= addr_nxt;
    io_r <= io_nxt;
  end

  // byte store
  logic ram_we;
  logic [DW-1:0] ram_rd_data;
  assign ram_we = wr_done && !io_r;
  byte_store_ram #(
    .DEPTH(host_port_pkg::RAM_DEPTH),
    .ADDR_W(host_port_pkg::RAM_ADDR_W),
    .DATA_W(DW)
  ) u_store (
    .clk_in(clk_in),
    .addr_in(addr_r), // see RL8
    .wr_en_in(ram_we),
    .wr_data_in(ad_s),
    .rd_data_out(ram_rd_data)
  );

  // control registers and host capture
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] pb_r;
  logic [7:0] pb_nxt;
  logic [7:0] pc_r;
  logic [7:0] pc_nxt;
  logic [1:0] lim_r;
  logic [1:0] lim_nxt;
  logic [7:0] pa_hold_r;
  logic [7:0] pa_hold_nxt;
  logic [7:0] pa_wr_r;
  logic [7:0] pa_wr_nxt;
  logic full_r;
  logic full_nxt;
  logic strobe_prev_r;
  logic strobe_prev_nxt;
  logic strobed_mode;
  logic pa_out_mode;
  logic capture;
  logic io_wr;
  assign strobed_mode = cmd_r[host_port_pkg::CMD_STROBED_BIT]; // see RL1
  assign pa_out_mode = cmd_r[host_port_pkg::CMD_PA_OUT_BIT];
  assign io_wr = wr_done && io_r;
  // strobe is active low: its trailing edge is the rise
  assign capture = strobed_mode && !pa_out_mode && !strobe_prev_r
                   && strobe_n_s; // see RL4 RL6
  always_comb begin
    cmd_nxt = cmd_r;
    pb_nxt = pb_r;
    pc_nxt = pc_r;
    lim_nxt = lim_r;
    pa_wr_nxt = pa_wr_r;
    pa_hold_nxt = pa_hold_r;
    full_nxt = full_r;
    strobe_prev_nxt = strobe_n_s;
    if (io_wr) begin
      case (addr_r)
        host_port_pkg::IO_ADDR_CMD: cmd_nxt = ad_s; // see RL1
        host_port_pkg::IO_ADDR_PORT_A: pa_wr_nxt = ad_s; // see RL10
        host_port_pkg::IO_ADDR_PORT_B: pb_nxt = ad_s; // see RL7
        host_port_pkg::IO_ADDR_PORT_C: pc_nxt = ad_s; // see RL7
        host_port_pkg::IO_ADDR_LIMIT: lim_nxt = ad_s[1:0]; // see RL12
        default: cmd_nxt = cmd_r;
      endcase
    end
    // reading the held byte frees the buffer; a new capture wins
    if (rd_done && io_r && addr_r == host_port_pkg::IO_ADDR_PORT_A) begin
      full_nxt = 1'b0; // see RL13
    end
    if (capture) begin
      pa_hold_nxt = pa_s; // see RL3 RL4
      full_nxt = 1'b1; // see RL5
    end
    // leaving strobed mode drops any pending handshake
    if (!strobed_mode) begin
      full_nxt = 1'b0;
    end
    if (ctl_rst) begin // see RL11
      cmd_nxt = host_port_pkg::CMD_RESET_VAL;
      pb_nxt = host_port_pkg::BYTE_ZERO;
      pc_nxt = host_port_pkg::BYTE_ZERO;
      lim_nxt = host_port_pkg::LIM_RESET_VAL;
      pa_wr_nxt = host_port_pkg::BYTE_ZERO;
      pa_hold_nxt = host_port_pkg::BYTE_ZERO;
      full_nxt = 1'b0;
      strobe_prev_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    cmd_r <= cmd_nxt;
    pb_r <= pb_nxt;
    pc_r <= pc_nxt;
    lim_r <= lim_nxt;
    pa_wr_r <= pa_wr_nxt;
    pa_hold_r <= pa_hold_nxt;
    full_r <= full_nxt;
    strobe_prev_r <= strobe_prev_nxt;
  end

  // read data and pin outputs, all registered
  logic [7:0] io_rd;
  logic [7:0] status;
  logic [7:0] ad_out_r;
  logic [7:0] ad_out_nxt;
  logic ad_oe_r;
  logic ad_oe_nxt;
  logic [7:0] pa_out_r;
  logic [7:0] pa_out_nxt;
  logic pa_oe_r;
  logic pa_oe_nxt;
  logic rdy_r;
  logic rdy_nxt;
  logic [7:0] head_b_r;
  logic [7:0] head_b_nxt;
  logic head9_r;
  logic head9_nxt;
  logic [1:0] lim_out_r;
  logic [1:0] lim_out_nxt;
  always_comb begin
    status = host_port_pkg::BYTE_ZERO;
    status[host_port_pkg::ST_FULL_BIT] = full_r;
    status[host_port_pkg::ST_STROBED_BIT] = strobed_mode;
    status[host_port_pkg::ST_FAIL_BIT] = fail_s;
    case (addr_r)
      host_port_pkg::IO_ADDR_STATUS: io_rd = status;
      host_port_pkg::IO_ADDR_PORT_A: io_rd = pa_out_mode ? pa_s : pa_hold_r;
      host_port_pkg::IO_ADDR_PORT_B: io_rd = pb_r;
      host_port_pkg::IO_ADDR_PORT_C: io_rd = pc_r;
      host_port_pkg::IO_ADDR_LIMIT: io_rd = {6'h00, lim_r};
      default: io_rd = host_port_pkg::BYTE_ZERO;
    endcase
  end

  always_comb begin
    ad_oe_nxt = (state_r == host_port_pkg::BUS_READ) && !rd_n_s; // see RL9
    ad_out_nxt = io_r ? io_rd : ram_rd_data; // see RL8 RL9
    pa_out_nxt = pa_wr_r;
    pa_oe_nxt = pa_out_mode && !strobed_mode; // see RL10
    rdy_nxt = full_nxt; // see RL5 RL13
    // head drive is cut at once on supply failure to protect the wires
    head_b_nxt = ctl_rst ? host_port_pkg::BYTE_ZERO : pb_nxt; // see RL7
    head9_nxt = ctl_rst ? 1'b0 : pc_nxt[host_port_pkg::PC_HEAD9_BIT];
    lim_out_nxt = lim_nxt; // see RL12
    if (rst_in) begin
      ad_oe_nxt = 1'b0;
      ad_out_nxt = host_port_pkg::BYTE_ZERO;
      pa_out_nxt = host_port_pkg::BYTE_ZERO;
      pa_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    ad_out_r <= ad_out_nxt;
    ad_oe_r <= ad_oe_nxt;
    pa_out_r <= pa_out_nxt;
    pa_oe_r <= pa_oe_nxt;
    rdy_r <= rdy_nxt;
    head_b_r <= head_b_nxt;
    head9_r <= head9_nxt;
    lim_out_r <= lim_out_nxt;
  end

  assign muxed_addr_data_bus_out = ad_out_r;
  assign muxed_addr_data_bus_oe_out = ad_oe_r;
  assign port_a_lines_out = pa_out_r;
  assign port_a_lines_oe_out = pa_oe_r;
  assign port_c_bit1_out = rdy_r;
  assign port_b_lines_out = head_b_r;
  assign port_c_bit4_out = head9_r;
  assign carriage_current_limit_out = lim_out_r[host_port_pkg::LIM_CARRIAGE_BIT];
  assign feed_current_limit_out = lim_out_r[host_port_pkg::LIM_FEED_BIT];
  assign ctrl_reset_out = gen_rst_r;

endmodule : strobed_host_input_port

// ===== verification/host_model.sv
// host computer model: presents a byte then gives one strobe pulse
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clk_in,
  // host pins
  output logic strobe_n_out,
  output logic [7:0] data_out
);
  initial begin
    strobe_n_out = 1'b1;
    data_out = 8'h00;
  end
  // late data settles only mid-pulse; lines scramble once hold runs out
  task automatic send(input logic [7:0] b, input int slow, input logic late);
    data_out <= late ? ~b : b;
    repeat (1 + slow) @(posedge clk_in);
    strobe_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    data_out <= b;
    repeat (2 + slow) @(posedge clk_in);
    strobe_n_out <= 1'b1;
    repeat (3 + slow) @(posedge clk_in);
    data_out <= ~b;
    repeat (3) @(posedge clk_in);
  endtask : send
endmodule : host_model

// ===== verification/strobed_host_input_port_props.sv
// concurrent checks on the strobed host input port boundary
`timescale 1ns/100ps
module strobed_host_input_port_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // watched pins
  input wire logic port_c_bit2_strobe_n_in,
  input wire logic port_c_bit1_out,
  input wire logic [7:0] port_b_lines_out,
  input wire logic port_c_bit4_out,
  input wire logic port_a_lines_oe_out,
  input wire logic carriage_current_limit_out,
  input wire logic feed_current_limit_out,
  input wire logic muxed_addr_data_bus_oe_out,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic chip_sel_n_in,
  input wire logic supply_fail_in,
  input wire logic ctrl_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // cycles since the last bus strobe or supply fault; state may only
  // move shortly after one of them
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  always_comb begin
    quiet_nxt = quiet_r;
    if (!rd_n_in || !wr_n_in || supply_fail_in) quiet_nxt = 4'h0;
    else if (quiet_r != 4'hf) quiet_nxt = quiet_r + 4'h1;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) quiet_r <= 4'h0;
    else quiet_r <= quiet_nxt;
  end
  chk_reset_values: assert property (
    $fell(rst_in) |-> carriage_current_limit_out && feed_current_limit_out
    && !port_c_bit1_out && port_b_lines_out == 8'h00)
    else $error("outputs not at reset level");
  chk_ready_cause: assert property (
    $rose(port_c_bit1_out) |-> $past(port_c_bit2_strobe_n_in, 2)
    && !$past(port_c_bit2_strobe_n_in, 4))
    else $error("ready rose without a strobe trailing edge");
  chk_ready_holds: assert property (
    $fell(port_c_bit1_out) |-> quiet_r < 4'h8)
    else $error("ready dropped without a controller access");
  chk_head_cause: assert property (
    $changed({port_c_bit4_out, port_b_lines_out}) |-> quiet_r < 4'h8)
    else $error("head drive moved without a write");
  chk_porta_cause: assert property (
    $changed(port_a_lines_oe_out) |-> quiet_r < 4'h8)
    else $error("port a direction moved without a write");
  chk_fail_reset: assert property (
    supply_fail_in [*5] |-> ctrl_reset_out && !port_c_bit4_out
    && port_b_lines_out == 8'h00)
    else $error("supply fault did not reset control");
  chk_read_drive: assert property (
    $rose(muxed_addr_data_bus_oe_out) |-> !$past(rd_n_in, 2)
    && !$past(chip_sel_n_in, 2))
    else $error("bus driven without a selected read");
  chk_read_release: assert property (
    rd_n_in [*6] |-> !muxed_addr_data_bus_oe_out)
    else $error("bus still driven after read");
  cov_ready: cover property ($rose(port_c_bit1_out));
  cov_read: cover property ($rose(muxed_addr_data_bus_oe_out));
  cov_fail: cover property ($rose(ctrl_reset_out));
endmodule : strobed_host_input_port_props

bind strobed_host_input_port strobed_host_input_port_props u_props (
  .clk_in, .rst_in, .port_c_bit2_strobe_n_in, .port_c_bit1_out,
  .port_b_lines_out, .port_c_bit4_out, .port_a_lines_oe_out,
  .carriage_current_limit_out, .feed_current_limit_out,
  .muxed_addr_data_bus_oe_out, .rd_n_in, .wr_n_in, .chip_sel_n_in,
  .supply_fail_in, .ctrl_reset_out
);

// ===== verification/strobed_host_input_port_tb_top.sv
// self-checking bench for the strobed host input port
`timescale 1ns/100ps
module strobed_host_input_port_tb_top;
  logic clk_in;
  logic rst_in = 1'b1;
  logic fail_in = 1'b0;
  logic ale = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic cs_n = 1'b1;
  logic io = 1'b0;
  logic [7:0] ad_tb = 8'h00;
  logic strobe_n, pa_oe, ready, head9, lim_c, lim_f, ad_oe, ctrl_rst;
  logic [7:0] host_d, pa_out, pb_out, ad_out, q, b, pa_wire, ad_wire;
  int fails = 0;
  int samples_checked = 0;
  int seed = 35979;
  // shared lines resolve from the port's output enables alone
  assign pa_wire = pa_oe ? pa_out : host_d;
  assign ad_wire = ad_oe ? ad_out : ad_tb;
  strobed_host_input_port DUT (
    .clk_in(clk_in), .rst_in(rst_in),
    .port_c_bit2_strobe_n_in(strobe_n), .port_a_lines_in(pa_wire),
    .port_a_lines_out(pa_out), .port_a_lines_oe_out(pa_oe),
    .port_c_bit1_out(ready), .port_b_lines_out(pb_out),
    .port_c_bit4_out(head9), .carriage_current_limit_out(lim_c),
    .feed_current_limit_out(lim_f), .muxed_addr_data_bus_in(ad_wire),
    .muxed_addr_data_bus_out(ad_out), .muxed_addr_data_bus_oe_out(ad_oe),
    .addr_latch_en_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .chip_sel_n_in(cs_n), .io_sel_in(io), .supply_fail_in(fail_in),
    .ctrl_reset_out(ctrl_rst)
  );
  host_model u_host (.clk_in(clk_in), .strobe_n_out(strobe_n),
    .data_out(host_d));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  function automatic logic [7:0] status(input logic full, input logic md);
    status = host_port_pkg::BYTE_ZERO;
    status[host_port_pkg::ST_FULL_BIT] = full;
    status[host_port_pkg::ST_STROBED_BIT] = md;
  endfunction : status
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one bus cycle; a read holds its strobe until the port drives the bus
  task automatic bus(input logic i, input logic [7:0] a, input logic w,
      input logic [7:0] d);
    int n;
    n = 0;
    io <= i;
    ad_tb <= a;
    ale <= 1'b1;
    cs_n <= 1'b0;
    @(posedge clk_in);
    ale <= 1'b0;
    repeat (3) @(posedge clk_in);
    ad_tb <= w ? d : ~a;
    wr_n <= ~w;
    rd_n <= w;
    repeat (3) @(posedge clk_in);
    while (!w && ad_oe !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 20) fails++;
    q = ad_out;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    cs_n <= 1'b1;
    ad_tb <= ~ad_tb;
    @(posedge clk_in);
  endtask : bus
  task automatic rd_chk(input logic i, input logic [7:0] a,
      input logic [7:0] exp);
    bus(i, a, 1'b0, 8'h00);
    check(q, exp);
  endtask : rd_chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check({lim_c, lim_f, ready, pa_oe, ad_oe, ctrl_rst, 2'h0}, 8'hc0);
    u_host.send(8'h5a, 0, 1'b0);
    check({7'h0, ready}, 8'h00);
    bus(1'b1, host_port_pkg::IO_ADDR_CMD, 1'b1, 8'h02);
    rd_chk(1'b1, host_port_pkg::IO_ADDR_STATUS, status(0, 1));
    for (int k = 0; k < 10; k++) begin
      b = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($random(seed));
      u_host.send(b, k % 3, k[0]);
      check({7'h0, ready}, 8'h01);
      rd_chk(1'b1, host_port_pkg::IO_ADDR_STATUS, status(1, 1));
      rd_chk(1'b1, host_port_pkg::IO_ADDR_PORT_A, b);
      check({7'h0, ready}, 8'h00);
      bus(1'b0, b, 1'b1, ~b);
      rd_chk(1'b0, b, ~b);
    end
    // corner cases: a second strobe overwrites, leaving strobed mode drops ready
    b = 8'($random(seed));
    u_host.send(~b, 1, 1'b0);
    u_host.send(b, 0, 1'b1);
    check({7'h0, ready}, 8'h01);
    rd_chk(1'b1, host_port_pkg::IO_ADDR_PORT_A, b);
    check({7'h0, ready}, 8'h00);
    u_host.send(b, 2, 1'b0);
    bus(1'b1, host_port_pkg::IO_ADDR_CMD, 1'b1, 8'h03);
    check({pa_oe, 6'h0, ready}, 8'h01);
    bus(1'b1, host_port_pkg::IO_ADDR_CMD, 1'b1, 8'h00);
    check({7'h0, ready}, 8'h00);
    $display("test host capture done");
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      bus(1'b1, host_port_pkg::IO_ADDR_PORT_B, 1'b1, b);
      bus(1'b1, host_port_pkg::IO_ADDR_PORT_C, 1'b1,
          {3'h0, b[0], 4'h0});
      check(pb_out, b);
      check({7'h0, head9}, {7'h0, b[0]});
      rd_chk(1'b1, host_port_pkg::IO_ADDR_PORT_B, b);
      bus(1'b1, host_port_pkg::IO_ADDR_LIMIT, 1'b1, k[7:0]);
      check({6'h0, lim_f, lim_c}, k[7:0]);
      rd_chk(1'b1, host_port_pkg::IO_ADDR_LIMIT, k[7:0]);
    end
    rd_chk(1'b1, 8'h07, 8'h00);
    $display("test head and limits done");
    bus(1'b1, host_port_pkg::IO_ADDR_CMD, 1'b1, 8'h01);
    b = 8'($random(seed));
    bus(1'b1, host_port_pkg::IO_ADDR_PORT_A, 1'b1, b);
    check({pa_oe, 7'h0}, 8'h80);
    rd_chk(1'b1, host_port_pkg::IO_ADDR_PORT_A, b);
    $display("test expansion port done");
    fail_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    check({ctrl_rst, pa_oe, lim_c, lim_f, 4'h0}, 8'hb0);
    check(pb_out, 8'h00);
    fail_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rd_chk(1'b1, host_port_pkg::IO_ADDR_STATUS, status(0, 0));
    $display("test supply fault done");
    final_report();
  end
endmodule : strobed_host_input_port_tb_top
